// ---- hdl/dpi_pkg.sv ----
/*
  constants, command encodings and types for the dram pin interface control block.
  assumes a single 200 MHz core clock shared with the sdram clock.
*/
`default_nettype none
package dpi_pkg;
  localparam int ADDR_W      = 14;
  localparam int LOW_W       = 2;
  localparam int DATA_W      = 64;
  localparam int ECC_W       = 8;
  localparam int COL_COPIES  = 3;
  localparam int WE_COPIES   = 4;
  localparam int SOCK_W      = 2;
  localparam int STRAP_HOLD  = 4;
  localparam logic [SOCK_W-1:0] SOCKET_NEAR = 2'h0;
  localparam int BIT4        = 4;
  localparam int BIT4_LOCAL  = BIT4 - LOW_W;
  localparam logic [1:0] CFG_ONE = 2'h1;
  // command encoding: {row_strobe_n, col_strobe_n, write_strobe_n}
  typedef enum logic [2:0] {
    CMD_NOP       = 3'b111,
    CMD_ACTIVATE  = 3'b011,
    CMD_READ      = 3'b101,
    CMD_WRITE     = 3'b100,
    CMD_PRECHARGE = 3'b010,
    CMD_REFRESH   = 3'b001,
    CMD_MODE      = 3'b000,
    CMD_TERMINATE = 3'b110
  } dpi_cmd_t;
  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_ROW  = 2'b01,
    PHASE_COL  = 2'b10,
    PHASE_ETC  = 2'b11
  } dpi_phase_t;
  typedef struct packed {
    dpi_cmd_t                cmd;
    logic [ADDR_W-1:0]       addr;
    logic [LOW_W-1:0]        low;
    logic [SOCK_W-1:0]       socket;
    logic [SOCK_W-1:0]       next_socket;
    logic                    write_data;
    logic [DATA_W-1:0]       data;
    logic [ECC_W-1:0]        ecc;
  } dpi_word_t;
  localparam int WORD_W = $bits(dpi_word_t);
endpackage
`default_nettype wire

// ---- hdl/dpi_stream_if.sv ----
/*
  valid/ready stream interface carrying command words between block modules.
  assumes both ends on core_clk.
*/
`default_nettype none
interface dpi_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- hdl/dpi_skid_buf.sv ----
/*
  two-entry buffer with valid and ready on both sides.
  assumes synchronous active-high reset on core_clk.
*/
`default_nettype none
module dpi_skid_buf #(
  parameter int W = 8
) (
  input  wire logic core_clk,
  input  wire logic srst,
  dpi_stream_if.snk in_s,
  dpi_stream_if.src out_s
);
  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         not_full;
  wire          push = in_s.valid && in_s.ready;
  wire          pop  = out_s.valid && out_s.ready;
  wire [1:0]    next_count = count + {1'b0, push} - {1'b0, pop};
  // ready is its own flop, so no combinational path from sink ready to source
  assign in_s.ready  = not_full;
  assign out_s.valid = (count != 2'h0);
  assign out_s.data  = mem[rd_ptr];
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count    <= 2'h0;
      not_full <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count    <= next_count;
      not_full <= (next_count != 2'h2);
    end
  end
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end
  a_full_no_push: assert property (@(posedge core_clk) disable iff (srst) (count == 2'h2) |-> !in_s.ready)
    else $error("buffer accepts while full");
endmodule
`default_nettype wire

// ---- hdl/dpi_strap_sync.sv ----
/*
  three-stage synchroniser for the clock-enable strap and reset pins.
  assumes pins asynchronous to core_clk; a change counts when stages two and three agree.
*/
`default_nettype none
module dpi_strap_sync #(
  parameter int N = 1
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [N-1:0] pin,
  output logic      [N-1:0] level
);
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        s1[i] <= pin[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (srst) begin
          level[i] <= 1'b1;
        end else if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- hdl/dpi_pin_ctrl.sv ----
/*
  pin-level control of the dram interface: strobes, address, write enables,
  data and check bus direction, clock enable with strap sampling.
  assumes an upstream scheduler that issues one command word per cycle and
  keeps banks precharged before it asks for power-down.
*/
// Notes on behaviour
// - the three column strobe copies are driven from one register, identical; copy3 in config one has its own register.
// - column address is valid in the cycle column strobe is low.
// - each command is row, column and write strobes on one edge.
// - shared pin: column strobe copy in config one, address bit 4 in two.
// - config two bit 4 copy changes only for accesses whose socket or next socket is 0.
// - when updated the bit 4 copy equals main address bit 4.
// - 14-bit main address bus carries row then column.
// - low address pair completes address, steps during edo bursts.
// - low address pair changes only for accesses whose socket or next socket is 0.
// - four write strobe copies of one logical write enable.
// - 64-bit data bus driven on writes, received on reads.
// - check bus outputs only while writing, inputs otherwise.
// - clock enable high for operation, low for power-down.
// - clock enable drops only when all banks are precharged.
// - power-down is used only for own array power management.
// - clock enable is an input sampling strap until 4 clocks after cpu reset.
// - row address is valid in the cycle row strobe is low.
`default_nettype none
module dpi_pin_ctrl
  import dpi_pkg::*;
#(
  parameter int BURST_LEN = 4
) (
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  input  wire logic [1:0]                    board_cfg,
  input  wire logic                          device_reset_in_n,
  input  wire logic                          cpu_reset_out_n,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire logic [dpi_pkg::WORD_W-1:0]    req_word,
  input  wire logic                          edo_mode,
  input  wire logic                          power_down_req,
  input  wire logic                          all_banks_precharged,
  output logic [dpi_pkg::COL_COPIES-1:0]     col_strobe_n,
  output logic                               col_strobe_copy3_n,
  output logic [dpi_pkg::COL_COPIES-1:0]     row_strobe_n,
  output logic [dpi_pkg::WE_COPIES-1:0]      write_strobe_n,
  output logic [dpi_pkg::ADDR_W-1:0]         dram_addr_main,
  output logic [dpi_pkg::LOW_W-1:0]          near_socket_addr_low,
  input  wire logic [dpi_pkg::DATA_W-1:0]    dram_data_bus_in,
  output logic [dpi_pkg::DATA_W-1:0]         dram_data_bus_out,
  output logic                               dram_data_bus_oe,
  input  wire logic [dpi_pkg::ECC_W-1:0]     dram_check_bus_in,
  output logic [dpi_pkg::ECC_W-1:0]          dram_check_bus_out,
  output logic                               dram_check_bus_oe,
  input  wire logic                          clk_enable_in,
  output logic                               clk_enable_out,
  output logic                               clk_enable_oe,
  output logic                               strap_value,
  output logic [dpi_pkg::DATA_W-1:0]         rd_data,
  output logic [dpi_pkg::ECC_W-1:0]          rd_check,
  output logic                               rd_valid
);
  import dpi_pkg::*;

  dpi_stream_if #(.W(WORD_W)) up_s ();
  dpi_stream_if #(.W(WORD_W)) dn_s ();

  assign up_s.valid = req_valid;
  assign up_s.data  = req_word;
  assign req_ready  = up_s.ready;

  // buffer keeps a word safe while a burst or power-down stalls the pins
  dpi_skid_buf #(.W(WORD_W)) u_buf (
    .core_clk (core_clk),
    .srst     (srst),
    .in_s     (up_s),
    .out_s    (dn_s)
  );

  logic [2:0] pin_sync;
  dpi_strap_sync #(.N(3)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .pin      ({clk_enable_in, cpu_reset_out_n, device_reset_in_n}),
    .level    (pin_sync)
  );
  wire dev_rst_n_s = pin_sync[0];
  wire cpu_rst_n_s = pin_sync[1];
  wire cke_pin_s   = pin_sync[2];

  // strap window: from device reset until STRAP_HOLD clocks after cpu reset release
  logic [2:0]  strap_cnt;
  logic        strap_window;
  wire         next_strap_window = !dev_rst_n_s ? 1'b1 :
                                   (strap_window && cpu_rst_n_s && (strap_cnt == 3'(STRAP_HOLD - 1))) ? 1'b0 :
                                   strap_window;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strap_window <= 1'b1;
      strap_cnt    <= 3'h0;
      strap_value  <= 1'b0;
    end else begin
      strap_window <= next_strap_window;
      if (!dev_rst_n_s || !cpu_rst_n_s) begin
        strap_cnt <= 3'h0;
      end else if (strap_window) begin
        strap_cnt <= strap_cnt + 3'h1;
      end
      if (strap_window) begin
        strap_value <= cke_pin_s;
      end
    end
  end

  // board configuration latched once on the first cycle after reset
  logic cfg_locked;
  logic cfg_one;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_locked <= 1'b0;
      cfg_one    <= 1'b1;
    end else if (!cfg_locked) begin
      cfg_locked <= 1'b1;
      cfg_one    <= (board_cfg == CFG_ONE);
    end
  end

  // power-down: only on explicit request from array power management
  logic pd_active;
  wire  next_pd_active = pd_active ? power_down_req :
                         (power_down_req && all_banks_precharged && !dn_s.valid);
  // a power-down request is ignored while the strap window holds the pin as input
  wire  next_pd        = !strap_window && next_pd_active;
  wire  next_cke_out   = !next_pd;

  dpi_word_t  cur;
  assign cur = dpi_word_t'(dn_s.data);

  dpi_phase_t phase;
  logic [2:0] burst_cnt;
  wire        edo_burst  = edo_mode && cur.cmd inside {CMD_READ, CMD_WRITE};
  wire        burst_done = (burst_cnt == 3'(BURST_LEN - 1));
  wire        pins_live  = !strap_window && !pd_active;
  wire        burst_end  = (phase == PHASE_ETC) && burst_done;
  // a burst word is issued once and held in the buffer until its last beat
  wire        take_word  = dn_s.valid && pins_live && (phase != PHASE_ETC);
  assign dn_s.ready = (take_word && !edo_burst) || burst_end;

  wire near_hit = (cur.socket == SOCKET_NEAR) || (cur.next_socket == SOCKET_NEAR);
  wire is_write = (cur.cmd == CMD_WRITE);

  wire dpi_cmd_t next_cmd   = take_word ? cur.cmd : CMD_NOP;
  wire [LOW_W-1:0] next_low = (phase == PHASE_ETC) ? near_socket_addr_low + 2'h1 : cur.low;
  wire next_bit4            = cur.addr[BIT4];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase     <= PHASE_IDLE;
      burst_cnt <= 3'h0;
      pd_active <= 1'b0;
    end else begin
      pd_active <= next_pd;
      if (take_word && edo_burst && phase != PHASE_ETC) begin
        phase     <= PHASE_ETC;
        burst_cnt <= 3'h0;
      end else if (phase == PHASE_ETC) begin
        burst_cnt <= burst_cnt + 3'h1;
        phase     <= burst_done ? PHASE_IDLE : PHASE_ETC;
      end else if (take_word) begin
        phase <= (cur.cmd == CMD_ACTIVATE) ? PHASE_ROW : PHASE_COL;
      end else begin
        phase <= PHASE_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      row_strobe_n         <= '1;
      col_strobe_n         <= '1;
      col_strobe_copy3_n   <= 1'b1;
      write_strobe_n       <= '1;
      dram_addr_main       <= '0;
      near_socket_addr_low <= '0;
      dram_data_bus_out    <= '0;
      dram_data_bus_oe     <= 1'b0;
      dram_check_bus_out   <= '0;
      dram_check_bus_oe    <= 1'b0;
      clk_enable_out       <= 1'b0;
      clk_enable_oe        <= 1'b0;
      rd_data              <= '0;
      rd_check             <= '0;
      rd_valid             <= 1'b0;
    end else begin
      row_strobe_n   <= {COL_COPIES{next_cmd[2]}};
      col_strobe_n   <= {COL_COPIES{next_cmd[1]}};
      write_strobe_n <= {WE_COPIES{next_cmd[0]}};
      if (cfg_one) begin
        col_strobe_copy3_n <= next_cmd[1];
      end else if (take_word && near_hit) begin
        col_strobe_copy3_n <= next_bit4;
      end
      if (take_word) begin
        dram_addr_main <= cur.addr;
      end
      if ((take_word || phase == PHASE_ETC) && near_hit) begin
        near_socket_addr_low <= next_low;
      end
      dram_data_bus_oe  <= take_word && is_write;
      dram_check_bus_oe <= take_word && is_write;
      if (take_word && is_write) begin
        dram_data_bus_out  <= cur.data;
        dram_check_bus_out <= cur.ecc;
      end
      // read data stands on the bus in the same cycle the read command is on the pins
      rd_valid <= ({row_strobe_n[0], col_strobe_n[0], write_strobe_n[0]} == CMD_READ);
      rd_data  <= dram_data_bus_in;
      rd_check <= dram_check_bus_in;
      clk_enable_oe  <= !next_strap_window;
      clk_enable_out <= !next_strap_window && next_cke_out;
    end
  end

  a_col_copies: assert property (@(posedge core_clk) disable iff (srst)
    (col_strobe_n == {COL_COPIES{col_strobe_n[0]}}))
    else $error("column strobe copies differ");
  a_we_copies: assert property (@(posedge core_clk) disable iff (srst)
    (write_strobe_n == {WE_COPIES{write_strobe_n[0]}}))
    else $error("write strobe copies differ");
  a_cmd_encode: assert property (@(posedge core_clk) disable iff (srst)
    take_word |=> ({row_strobe_n[0], col_strobe_n[0], write_strobe_n[0]} == $past(cur.cmd)))
    else $error("command encoding mismatch");
  a_addr_valid: assert property (@(posedge core_clk) disable iff (srst)
    take_word |=> (dram_addr_main == $past(cur.addr)))
    else $error("address not presented with strobe");
  a_cfg1_copy3: assert property (@(posedge core_clk) disable iff (srst)
    (cfg_one && cfg_locked) |=> (col_strobe_copy3_n == $past(next_cmd[1])))
    else $error("shared pin not column strobe in config one");
  a_bit4_hold: assert property (@(posedge core_clk) disable iff (srst)
    (!cfg_one && cfg_locked && !(take_word && near_hit)) |=> $stable(col_strobe_copy3_n))
    else $error("bit 4 copy changed for far socket");
  a_bit4_value: assert property (@(posedge core_clk) disable iff (srst)
    (!cfg_one && cfg_locked && take_word && near_hit) |=> (col_strobe_copy3_n == dram_addr_main[BIT4]))
    else $error("bit 4 copy differs from main bit 4");
  a_low_hold: assert property (@(posedge core_clk) disable iff (srst)
    !((take_word || phase == PHASE_ETC) && near_hit) |=> $stable(near_socket_addr_low))
    else $error("low address changed for far socket");
  a_burst_quiet: assert property (@(posedge core_clk) disable iff (srst)
    (phase == PHASE_ETC) |=> ({row_strobe_n[0], col_strobe_n[0], write_strobe_n[0]} == CMD_NOP))
    else $error("command issued inside an edo burst");
  a_burst_step: assert property (@(posedge core_clk) disable iff (srst)
    (phase == PHASE_ETC && near_hit) |=> (near_socket_addr_low == $past(near_socket_addr_low) + 2'h1))
    else $error("low address did not step in burst");
  a_check_dir: assert property (@(posedge core_clk) disable iff (srst)
    dram_check_bus_oe |-> ($past(take_word) && $past(is_write)))
    else $error("check bus driven outside a write");
  a_cke_precharge: assert property (@(posedge core_clk) disable iff (srst)
    ($rose(pd_active)) |-> $past(all_banks_precharged) && $past(power_down_req))
    else $error("power-down without precharge");
  a_strap_input: assert property (@(posedge core_clk) disable iff (srst)
    strap_window |-> !clk_enable_oe)
    else $error("clock enable driven during strap window");
  a_cke_level: assert property (@(posedge core_clk) disable iff (srst)
    (clk_enable_oe && !pd_active) |-> clk_enable_out)
    else $error("clock enable low while not powered down");
endmodule
`default_nettype wire

// ---- verif/dpi_dram_model.sv ----
/*
  behavioural dram array on the far side of the pin block.
  assumes resolved data and check lines from the bench; idle lines pulled down there.
*/
`default_nettype none
module dpi_dram_model
  import dpi_pkg::*;
(
  input  wire logic                             core_clk,
  input  wire logic [2:0]                       cmd_pins,
  input  wire logic [dpi_pkg::ADDR_W-1:0]       addr,
  input  wire logic [dpi_pkg::LOW_W-1:0]        low,
  input  wire logic [dpi_pkg::DATA_W-1:0]       wr_data,
  input  wire logic [dpi_pkg::ECC_W-1:0]        wr_check,
  output logic [dpi_pkg::DATA_W+ECC_W-1:0]      rd_word,
  output logic                                  rd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0]        row_lat = '0;
  logic [DATA_W+ECC_W-1:0]  mem [logic [29:0]];
  wire  [29:0]              key = {row_lat, addr, low};
  // unwritten cells answer with an address pattern so a stale read shows
  always @* begin
    rd_en = (cmd_pins == CMD_READ);
    rd_word = mem.exists(key) ? mem[key] : {{4{key[15:0]}}, key[7:0]};
  end
  always @(posedge core_clk) begin
    if (cmd_pins == CMD_ACTIVATE) row_lat <= addr;
    if (cmd_pins == CMD_WRITE) mem[key] = {wr_data, wr_check};
  end
endmodule
`default_nettype wire

// ---- verif/dram_pin_interface_control_tb.sv ----
/*
  self-checking bench: queue model of the pins compared at every command and read.
  assumes dpi_dram_model as the array; strap and reset pins are driven here.
*/
`default_nettype none
module dram_pin_interface_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpi_pkg::*;
  localparam int LIMIT = 20000;
  logic core_clk = 1'b0, srst = 1'b1, device_reset_in_n = 1'b0, cpu_reset_out_n = 1'b0;
  logic req_valid = 1'b0, edo_mode = 1'b0, power_down_req = 1'b0, all_banks_precharged = 1'b0;
  logic strap = 1'b0, mon = 1'b0, req_ready, col_strobe_copy3_n, rd_en, rd_valid, strap_value;
  logic dram_data_bus_oe, dram_check_bus_oe, clk_enable_in, clk_enable_out, clk_enable_oe;
  logic [1:0] board_cfg = 2'h2, near_socket_addr_low, e_low;
  logic [2:0] col_strobe_n, row_strobe_n;
  logic [3:0] write_strobe_n;
  logic [13:0] dram_addr_main, e_row;
  logic [63:0] dram_data_bus_in, dram_data_bus_out, rd_data;
  logic [7:0] dram_check_bus_in, dram_check_bus_out, rd_check;
  logic [71:0] rd_word, rq [$], mem_tb [logic [29:0]];
  logic [WORD_W-1:0] req_word = '0;
  logic [29:0] k;
  logic e_b4;
  dpi_word_t q [$], w;
  int err_total = 0, total_checks = 0, cyc = 0;
  wire [2:0] cmd_pins = {row_strobe_n[0], col_strobe_n[0], write_strobe_n[0]};

  // idle data and check lines sit at their pull-down level
  assign dram_data_bus_in = dram_data_bus_oe ? dram_data_bus_out : (rd_en ? rd_word[71:8] : '0);
  assign dram_check_bus_in = dram_check_bus_oe ? dram_check_bus_out : (rd_en ? rd_word[7:0] : '0);
  assign clk_enable_in = clk_enable_oe ? clk_enable_out : strap;

  dpi_pin_ctrl i_dpi_pin_ctrl (.core_clk, .srst, .board_cfg, .device_reset_in_n, .cpu_reset_out_n,
    .req_valid, .req_ready, .req_word, .edo_mode, .power_down_req, .all_banks_precharged,
    .col_strobe_n, .col_strobe_copy3_n, .row_strobe_n, .write_strobe_n, .dram_addr_main,
    .near_socket_addr_low, .dram_data_bus_in, .dram_data_bus_out, .dram_data_bus_oe,
    .dram_check_bus_in, .dram_check_bus_out, .dram_check_bus_oe, .clk_enable_in,
    .clk_enable_out, .clk_enable_oe, .strap_value, .rd_data, .rd_check, .rd_valid);
  dpi_dram_model i_dpi_dram_model (.core_clk, .cmd_pins, .addr(dram_addr_main),
    .low(near_socket_addr_low), .wr_data(dram_data_bus_in), .wr_check(dram_check_bus_in),
    .rd_word, .rd_en);

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk_pin(string nm, logic [71:0] e, logic [71:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rd(logic [71:0] e, logic [71:0] g);
    chk_pin("read data", e, g);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      finish_test();
    end
  end

  always @(posedge core_clk) begin
    if (!srst && mon) begin
      if (req_valid && req_ready) q.push_back(dpi_word_t'(req_word));
      if (rd_valid === 1'b1) chk_rd(rq.size() > 0 ? rq.pop_front() : '1, {rd_data, rd_check});
      if (board_cfg == CFG_ONE) chk_pin("copy3", col_strobe_n[0], col_strobe_copy3_n);
      if (cmd_pins !== CMD_NOP) begin
        w = q.pop_front();
        chk_pin("cmd", w.cmd, cmd_pins);
        chk_pin("copies", {{3{w.cmd[2]}}, {3{w.cmd[1]}}, {4{w.cmd[0]}}},
                {row_strobe_n, col_strobe_n, write_strobe_n});
        chk_pin("addr", w.addr, dram_addr_main);
        if (w.socket == SOCKET_NEAR || w.next_socket == SOCKET_NEAR) begin
          e_low = w.low;
          e_b4 = w.addr[BIT4];
        end
        chk_pin("low", e_low, near_socket_addr_low);
        if (board_cfg != CFG_ONE) chk_pin("bit4", e_b4, col_strobe_copy3_n);
        chk_pin("wr oe", {2{w.write_data}}, {dram_data_bus_oe, dram_check_bus_oe});
        if (w.write_data) chk_pin("wr", {w.data, w.ecc}, {dram_data_bus_out, dram_check_bus_out});
        k = {e_row, w.addr, e_low};
        if (w.cmd == CMD_ACTIVATE) e_row = w.addr;
        if (w.cmd == CMD_WRITE) mem_tb[k] = {w.data, w.ecc};
        if (w.cmd == CMD_READ) rq.push_back(mem_tb.exists(k) ? mem_tb[k] : {{4{k[15:0]}}, k[7:0]});
      end else chk_pin("idle oe", 2'h0, {dram_data_bus_oe, dram_check_bus_oe});
    end
  end

  function automatic dpi_word_t rnd(bit near);
    dpi_word_t r;
    dpi_cmd_t c [7] = '{CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE, CMD_TERMINATE};
    r.cmd = c[$urandom_range(6)];
    r.addr = ADDR_W'($urandom);
    r.low = LOW_W'($urandom);
    r.socket = near ? SOCKET_NEAR : SOCK_W'($urandom_range(2));
    r.next_socket = SOCK_W'($urandom_range(2));
    r.write_data = (r.cmd == CMD_WRITE);
    r.data = {$urandom, $urandom};
    r.ecc = ECC_W'($urandom);
    return r;
  endfunction

  task automatic send(dpi_word_t x);
    int n;
    req_word = x;
    req_valid = 1'b1;
    n = 0;
    @(posedge core_clk);
    while (req_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 50) chk_pin("accept", 1, 0);
    #1;
  endtask

  task automatic wait_cke(logic v, int lim);
    int n;
    n = 0;
    while (clk_enable_out !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk_pin("cke", v, clk_enable_out);
  endtask

  task automatic do_reset(logic [1:0] cfg);
    int n;
    mon = 1'b0;
    srst = 1'b1;
    device_reset_in_n = 1'b0;
    cpu_reset_out_n = 1'b0;
    all_banks_precharged = 1'b0;
    board_cfg = cfg;
    strap = ~strap;
    q.delete();
    rq.delete();
    e_row = '0;
    e_low = '0;
    e_b4 = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 srst = 1'b0;
    device_reset_in_n = 1'b1;
    mon = 1'b1;
    repeat (8) @(posedge core_clk);
    chk_pin("cke oe early", 0, clk_enable_oe);
    #1 cpu_reset_out_n = 1'b1;
    n = 0;
    while (clk_enable_oe !== 1'b1 && n < 30) begin
      @(posedge core_clk);
      n++;
    end
    chk_pin("cke window", 1, n > STRAP_HOLD && n < 30);
    chk_pin("strap", strap, strap_value);
    wait_cke(1'b1, 5);
    #1;
  endtask

  // the first word goes to socket 0 so the near copies start from a known value
  task automatic run(int cnt);
    dpi_word_t x;
    x = rnd(1);
    x.cmd = CMD_ACTIVATE;
    x.write_data = 1'b0;
    send(x);
    x = rnd(1);
    x.cmd = CMD_WRITE;
    x.write_data = 1'b1;
    send(x);
    x.cmd = CMD_READ;
    x.write_data = 1'b0;
    send(x);
    repeat (cnt) send(rnd(0));
    req_valid = 1'b0;
    repeat (20) @(posedge core_clk);
    chk_pin("left", 0, q.size() + rq.size());
    #1;
  endtask

  initial begin
    int n;
    void'($urandom(21));
    do_reset(2'h2);
    run(40);
    power_down_req = 1'b1;
    repeat (10) @(posedge core_clk);
    chk_pin("cke held", 1, clk_enable_out);
    #1 all_banks_precharged = 1'b1;
    wait_cke(1'b0, 10);
    #1 req_word = rnd(0);
    req_valid = 1'b1;
    n = 0;
    repeat (6) begin
      @(posedge core_clk);
      if (req_ready === 1'b1) begin
        n++;
        #1 req_word = rnd(0);
      end
    end
    chk_pin("buffer fill", 2, n);
    #1 req_valid = 1'b0;
    power_down_req = 1'b0;
    wait_cke(1'b1, 10);
    run(8);
    edo_mode = 1'b1;
    run(8);
    edo_mode = 1'b0;
    do_reset(CFG_ONE);
    run(20);
    finish_test();
  end
endmodule
`default_nettype wire
